// ---- hdl/swta_addr_table.sv ----
`timescale 1ns/1ns
module swta_addr_table #(
	parameter int ENTRIES = 16,
	parameter int IW      = $clog2(ENTRIES)
) (
	input  wire logic                   clk,            // core clock
	input  wire logic                   rst_b,          // async reset, low
	input  wire logic                   learn_req_i,    // learn pulse
	input  wire logic [IW-1:0]          learn_idx_i,    // learn location
	input  wire swta_pkg::swta_learn_t  learn_data_i,   // learned contents
	input  wire logic                   access_req_i,   // entry hit pulse
	input  wire logic [IW-1:0]          access_idx_i,   // hit location
	input  wire logic                   age_tick_i,     // aging sweep pulse
	input  wire logic                   mgmt_inval_i,   // invalidate pulse
	input  wire logic                   mgmt_setst_i,   // install static
	input  wire logic                   mgmt_clrst_i,   // release static
	input  wire logic [IW-1:0]          sel_idx_i,      // reported entry
	output logic      [31:0]            result_o        // search result word
);
	swta_pkg::swta_addr_entry_t tbl_ff [ENTRIES];
	swta_pkg::swta_addr_entry_t lrn_ent;

	function automatic logic [31:0] fmt_result(input swta_pkg::swta_addr_entry_t e);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[swta_pkg::RES_PRIO_LSB +: 3] = e.prio;
		w[swta_pkg::RES_VALID_BIT]     = e.valid;
		w[swta_pkg::RES_AGE_BIT]       = e.age;
		if (e.mcast) begin
			w[swta_pkg::RES_STATIC_BIT]    = e.map[0];
			w[swta_pkg::RES_PORT_LSB +: 5] = e.map[5:1];
			w[swta_pkg::RES_MAPHI_LSB +: 11] = e.map[16:6];
		end else begin
			w[swta_pkg::RES_STATIC_BIT]    = e.static_flag;
			w[swta_pkg::RES_PORT_LSB +: 5] = e.map[4:0];
		end
		return w;
	endfunction

	always_comb begin
		lrn_ent             = '0;
		lrn_ent.valid       = 1'b1;
		lrn_ent.age         = 1'b1;
		lrn_ent.mcast       = learn_data_i.mcast;
		lrn_ent.map         = learn_data_i.map;
		lrn_ent.prio        = learn_data_i.prio;
	end

	// management actions come last so they win over learning
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < ENTRIES; i++) tbl_ff[i] <= '0;
		end else begin
			for (int i = 0; i < ENTRIES; i++) begin
				if (age_tick_i && tbl_ff[i].valid && !tbl_ff[i].static_flag) begin
					if (tbl_ff[i].age) tbl_ff[i].age <= 1'b0;
					else tbl_ff[i].valid <= 1'b0;
				end
			end
			if (access_req_i && tbl_ff[access_idx_i].valid)
				tbl_ff[access_idx_i].age <= 1'b1;
			if (learn_req_i && !tbl_ff[learn_idx_i].valid
			    && !tbl_ff[learn_idx_i].static_flag)
				tbl_ff[learn_idx_i] <= lrn_ent;
			if (mgmt_inval_i) tbl_ff[sel_idx_i].valid <= 1'b0;
			if (mgmt_setst_i) begin
				tbl_ff[sel_idx_i].static_flag <= 1'b1;
				tbl_ff[sel_idx_i].valid       <= 1'b1;
			end
			if (mgmt_clrst_i) tbl_ff[sel_idx_i].static_flag <= 1'b0;
		end
	end

	assign result_o = fmt_result(tbl_ff[sel_idx_i]);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_LEARN_GUARD: assert property (
		learn_req_i && (tbl_ff[learn_idx_i].valid || tbl_ff[learn_idx_i].static_flag)
		&& !access_req_i && !age_tick_i && !mgmt_inval_i && !mgmt_setst_i && !mgmt_clrst_i
		|=> tbl_ff[$past(learn_idx_i)] == $past(tbl_ff[learn_idx_i]))
		else $error("learning overwrote a valid or static entry");
	AST_AGE_EXPIRE: assert property (
		age_tick_i && tbl_ff[sel_idx_i].valid && !tbl_ff[sel_idx_i].static_flag
		&& !tbl_ff[sel_idx_i].age && !learn_req_i && !mgmt_setst_i
		|=> !result_o[swta_pkg::RES_VALID_BIT] || (sel_idx_i != $past(sel_idx_i)))
		else $error("unused dynamic entry not expired");
	AST_STATIC_KEEP: assert property (
		tbl_ff[sel_idx_i].static_flag && tbl_ff[sel_idx_i].valid && age_tick_i
		&& !mgmt_inval_i && !mgmt_clrst_i && $stable(sel_idx_i)
		|=> tbl_ff[$past(sel_idx_i)].valid)
		else $error("static entry aged out");
endmodule

// ---- hdl/swta_switch_table_regs.sv ----
`timescale 1ns/1ns
// Functional notes
// - result valid bit 3 set only for a live, unexpired, unfreed station entry
// - valid clears when entry empty, aged out, or invalidated by management
// - automatic learning only into a location neither valid nor static
// - bit 5 reports static for unicast entries; static entries skip learning and aging
// - bit 4 reports age; set on learn or access, cleared by aging
// - unused valid dynamic entry loses valid after aging period; static ignores age
// - unicast entry reports attached port number in bits 10:6
// - multicast entry reports group map across bits 21:11, 10:6 and 5
// - bits 2:0 report the entry priority
// - start bit clears when write done or read data sits in entry register
// - index bits 11:0 select the VLAN table entry accessed next
// - entry holds untag map 39:23, forward map 22:6, tree index 5:1, valid 0
module swta_switch_table_regs #(
	parameter int ENTRIES    = 16,
	parameter int VLAN_DEPTH = 4096
) (
	input  wire logic                  clk,           // 250 MHz core clock
	input  wire logic                  rst_b,         // async reset, low
	input  wire logic                  wb_cyc_i,      // wishbone cycle
	input  wire logic                  wb_stb_i,      // wishbone strobe
	input  wire logic                  wb_we_i,       // wishbone write
	input  wire logic [9:0]            wb_adr_i,      // byte address
	input  wire logic [3:0]            wb_sel_i,      // byte enables
	input  wire logic [31:0]           wb_dat_i,      // write data
	output logic      [31:0]           wb_dat_o,      // read data
	output logic                       wb_ack_o,      // acknowledge
	input  wire logic                  learn_req_i,   // learn pulse
	input  wire logic [$clog2(ENTRIES)-1:0] learn_idx_i, // learn location
	input  wire swta_pkg::swta_learn_t learn_data_i,  // learned contents
	input  wire logic                  access_req_i,  // entry hit pulse
	input  wire logic [$clog2(ENTRIES)-1:0] access_idx_i // hit location
);
	localparam int IW  = $clog2(ENTRIES);
	localparam int VAW = $clog2(VLAN_DEPTH);

	// ---------------------------------------------------------------
	// parameter checks
	// ---------------------------------------------------------------
	if (ENTRIES < 2 || ENTRIES > 256 || (1 << IW) != ENTRIES) begin : g_bad_entries
		$error("ENTRIES must be a power of two from 2 to 256");
	end
	if (VLAN_DEPTH < 2 || VLAN_DEPTH > 4096 || (1 << VAW) != VLAN_DEPTH) begin : g_bad_depth
		$error("VLAN_DEPTH must be a power of two from 2 to 4096");
	end

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
	                                            input logic [31:0] new_w,
	                                            input logic [3:0]  sel);
		logic [31:0] m;
		m = old_w;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) m[b*8 +: 8] = new_w[b*8 +: 8];
		end
		return m;
	endfunction

	logic                       ack_ff;
	logic [31:0]                dat_ff;
	logic                       cmd_start_ff;
	logic                       cmd_dir_ff;
	logic [swta_pkg::VID_W-1:0] vlan_index_ff;
	swta_pkg::swta_vlan_entry_t entry_ff;
	swta_pkg::swta_vlan_entry_t rd_q_ff;
	swta_pkg::swta_vt_state_t   state_ff;
	logic [IW-1:0]              addr_sel_ff;
	logic                       mgmt_inval_ff;
	logic                       mgmt_setst_ff;
	logic                       mgmt_clrst_ff;
	logic [31:0]                age_period_ff;
	logic [31:0]                age_cnt_ff;
	logic                       age_tick_ff;
	logic [31:0]                addr_result;
	logic [31:0]                rd_word;
	logic [31:0]                nxt_cmd;
	logic [31:0]                nxt_index;
	logic [31:0]                nxt_ent_lo;
	logic [31:0]                nxt_ent_hi;
	logic [31:0]                nxt_age_period;
	logic                       req;
	logic                       wr;
	logic                       rd;
	logic [7:0]                 idx;
	logic                       vid_ok;
	logic [VAW-1:0]             vaddr;

	swta_pkg::swta_vlan_entry_t vlan_table [VLAN_DEPTH];

	// ---------------------------------------------------------------
	// wishbone slave
	// ---------------------------------------------------------------
	// one wait state: ack is registered, drops the cycle after it rises
	assign req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr  = req && wb_we_i;
	assign rd  = req && !wb_we_i;
	assign idx = wb_adr_i[9:2];

	always_comb begin
		case (idx)
			swta_pkg::IDX_ADDR_RESULT: rd_word = addr_result;
			swta_pkg::IDX_ADDR_CTRL:   rd_word = {{(32-IW){1'b0}}, addr_sel_ff};
			swta_pkg::IDX_AGE_PERIOD:  rd_word = age_period_ff;
			swta_pkg::IDX_VLAN_CMD: begin
				rd_word = 32'h0000_0000;
				rd_word[swta_pkg::CMD_START_BIT] = cmd_start_ff;
				rd_word[swta_pkg::CMD_DIR_BIT]   = cmd_dir_ff;
			end
			swta_pkg::IDX_VLAN_INDEX:  rd_word = {20'h0_0000, vlan_index_ff};
			swta_pkg::IDX_VLAN_ENT_LO: rd_word = entry_ff[31:0];
			swta_pkg::IDX_VLAN_ENT_HI: rd_word = {24'h00_0000, entry_ff[39:32]};
			default:                   rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= req;
			if (rd) dat_ff <= rd_word;
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// ---------------------------------------------------------------
	// vlan table command and index
	// ---------------------------------------------------------------
	assign nxt_cmd   = merge_bytes({24'h00_0000, 7'h00, cmd_dir_ff}, wb_dat_i, wb_sel_i);
	assign nxt_index = merge_bytes({20'h0_0000, vlan_index_ff}, wb_dat_i, wb_sel_i);

	// writes while busy are dropped so the access in flight stays coherent
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_start_ff <= swta_pkg::CMD_RST[swta_pkg::CMD_START_BIT];
			cmd_dir_ff   <= swta_pkg::CMD_RST[swta_pkg::CMD_DIR_BIT];
		end else if (state_ff == swta_pkg::VT_FINISH) begin
			cmd_start_ff <= 1'b0;
		end else if (wr && idx == swta_pkg::IDX_VLAN_CMD && !cmd_start_ff && wb_sel_i[0]) begin
			cmd_start_ff <= wb_dat_i[swta_pkg::CMD_START_BIT];
			cmd_dir_ff   <= nxt_cmd[swta_pkg::CMD_DIR_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vlan_index_ff <= swta_pkg::INDEX_RST[swta_pkg::VID_W-1:0];
		end else if (wr && idx == swta_pkg::IDX_VLAN_INDEX && !cmd_start_ff) begin
			vlan_index_ff <= nxt_index[swta_pkg::VID_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// vlan entry register
	// ---------------------------------------------------------------
	assign nxt_ent_lo = merge_bytes(entry_ff[31:0], wb_dat_i, wb_sel_i);
	assign nxt_ent_hi = merge_bytes({24'h00_0000, entry_ff[39:32]}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			entry_ff <= '0;
		end else if (state_ff == swta_pkg::VT_FINISH && cmd_dir_ff == swta_pkg::DIR_READ) begin
			entry_ff <= rd_q_ff;
		end else if (wr && !cmd_start_ff && idx == swta_pkg::IDX_VLAN_ENT_LO) begin
			entry_ff[31:0] <= nxt_ent_lo;
		end else if (wr && !cmd_start_ff && idx == swta_pkg::IDX_VLAN_ENT_HI) begin
			entry_ff[39:32] <= nxt_ent_hi[7:0];
		end
	end

	// ---------------------------------------------------------------
	// vlan table access sequencer
	// ---------------------------------------------------------------
	assign vid_ok = 32'(vlan_index_ff) < VLAN_DEPTH;
	assign vaddr  = vlan_index_ff[VAW-1:0];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= swta_pkg::VT_IDLE;
		end else begin
			case (state_ff)
				swta_pkg::VT_IDLE:   if (cmd_start_ff) state_ff <= swta_pkg::VT_ACCESS;
				swta_pkg::VT_ACCESS: state_ff <= swta_pkg::VT_FINISH;
				swta_pkg::VT_FINISH: state_ff <= swta_pkg::VT_IDLE;
				default:             state_ff <= swta_pkg::VT_IDLE;
			endcase
		end
	end

	// table itself has no reset: contents are defined only once written
	always_ff @(posedge clk) begin
		if (state_ff == swta_pkg::VT_ACCESS && cmd_dir_ff != swta_pkg::DIR_READ && vid_ok)
			vlan_table[vaddr] <= entry_ff;
	end

	// out-of-range index reads back as an all-zero entry
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_q_ff <= '0;
		end else if (state_ff == swta_pkg::VT_ACCESS) begin
			rd_q_ff <= vid_ok ? vlan_table[vaddr] : '0;
		end
	end

	// ---------------------------------------------------------------
	// address table management and aging
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_sel_ff   <= '0;
			mgmt_inval_ff <= 1'b0;
			mgmt_setst_ff <= 1'b0;
			mgmt_clrst_ff <= 1'b0;
		end else begin
			mgmt_inval_ff <= 1'b0;
			mgmt_setst_ff <= 1'b0;
			mgmt_clrst_ff <= 1'b0;
			if (wr && idx == swta_pkg::IDX_ADDR_CTRL) begin
				if (wb_sel_i[0]) addr_sel_ff <= wb_dat_i[IW-1:0];
				if (wb_sel_i[2]) begin
					mgmt_inval_ff <= wb_dat_i[swta_pkg::CTRL_INVAL_BIT];
					mgmt_setst_ff <= wb_dat_i[swta_pkg::CTRL_SETST_BIT];
					mgmt_clrst_ff <= wb_dat_i[swta_pkg::CTRL_CLRST_BIT];
				end
			end
		end
	end

	assign nxt_age_period = merge_bytes(age_period_ff, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			age_period_ff <= swta_pkg::AGE_PERIOD_RST;
		end else if (wr && idx == swta_pkg::IDX_AGE_PERIOD) begin
			age_period_ff <= nxt_age_period;
		end
	end

	// period zero stops aging; an entry expires after two idle sweeps
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			age_cnt_ff  <= 32'h0000_0000;
			age_tick_ff <= 1'b0;
		end else if (age_period_ff == 32'h0000_0000) begin
			age_cnt_ff  <= 32'h0000_0000;
			age_tick_ff <= 1'b0;
		end else if (age_cnt_ff >= age_period_ff - 32'h0000_0001) begin
			age_cnt_ff  <= 32'h0000_0000;
			age_tick_ff <= 1'b1;
		end else begin
			age_cnt_ff  <= age_cnt_ff + 32'h0000_0001;
			age_tick_ff <= 1'b0;
		end
	end

	swta_addr_table #(
		.ENTRIES (ENTRIES)
	) u_addr_table (
		.clk          (clk),
		.rst_b        (rst_b),
		.learn_req_i  (learn_req_i),
		.learn_idx_i  (learn_idx_i),
		.learn_data_i (learn_data_i),
		.access_req_i (access_req_i),
		.access_idx_i (access_idx_i),
		.age_tick_i   (age_tick_ff),
		.mgmt_inval_i (mgmt_inval_ff),
		.mgmt_setst_i (mgmt_setst_ff),
		.mgmt_clrst_i (mgmt_clrst_ff),
		.sel_idx_i    (addr_sel_ff),
		.result_o     (addr_result)
	);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	AST_ACK_SINGLE: assert property (ack_ff |=> !ack_ff)
		else $error("ack held longer than one cycle");
	AST_START_CLEARS: assert property (
		$rose(cmd_start_ff) |-> cmd_start_ff [*3] ##1 !cmd_start_ff)
		else $error("start bit did not self clear after three cycles");
	AST_READ_LANDS: assert property (
		$fell(cmd_start_ff) && cmd_dir_ff == swta_pkg::DIR_READ |-> entry_ff == $past(rd_q_ff))
		else $error("start cleared before read data reached entry register");
	AST_WRITE_STORES: assert property (
		state_ff == swta_pkg::VT_ACCESS && cmd_dir_ff != swta_pkg::DIR_READ && vid_ok
		|=> vlan_table[$past(vaddr)] == $past(entry_ff))
		else $error("vlan write not stored at selected index");
	AST_INDEX_HOLD: assert property (
		cmd_start_ff && $past(cmd_start_ff) |-> $stable(vlan_index_ff) && $stable(cmd_dir_ff))
		else $error("index or direction changed during access");
	AST_READ_DATA: assert property (
		rd && idx == swta_pkg::IDX_VLAN_INDEX |=> wb_ack_o && wb_dat_o == {20'h0_0000, vlan_index_ff})
		else $error("index read back wrong");
	AST_AGE_TICK: assert property (
		age_tick_ff |-> $past(age_period_ff) != 32'h0000_0000 && age_cnt_ff == 32'h0000_0000)
		else $error("aging sweep out of step with period");
	AST_VALID_RESULT: assert property (
		$past(mgmt_inval_ff) && $stable(addr_sel_ff) && !$past(mgmt_setst_ff)
		|-> !addr_result[swta_pkg::RES_VALID_BIT] || $past(learn_req_i))
		else $error("freed entry still reported valid");

	COV_VLAN_READ:  cover property ($fell(cmd_start_ff) && cmd_dir_ff == swta_pkg::DIR_READ);
	COV_VLAN_WRITE: cover property ($fell(cmd_start_ff) && cmd_dir_ff != swta_pkg::DIR_READ);
	COV_AGE_SWEEP:  cover property (age_tick_ff ##1 !addr_result[swta_pkg::RES_VALID_BIT]);
endmodule

// ---- pkg/swta_pkg.sv ----
package swta_pkg;

	// ---------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ---------------------------------------------------------------
	localparam logic [7:0] IDX_ADDR_RESULT = 8'h48;
	localparam logic [7:0] IDX_ADDR_CTRL   = 8'h4C;
	localparam logic [7:0] IDX_AGE_PERIOD  = 8'h4D;
	localparam logic [7:0] IDX_VLAN_CMD    = 8'h60;
	localparam logic [7:0] IDX_VLAN_INDEX  = 8'h61;
	localparam logic [7:0] IDX_VLAN_ENT_LO = 8'h63;
	localparam logic [7:0] IDX_VLAN_ENT_HI = 8'h64;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int RES_PRIO_LSB   = 0;
	localparam int RES_VALID_BIT  = 3;
	localparam int RES_AGE_BIT    = 4;
	localparam int RES_STATIC_BIT = 5;
	localparam int RES_PORT_LSB   = 6;
	localparam int RES_MAPHI_LSB  = 11;
	localparam int CMD_START_BIT  = 7;
	localparam int CMD_DIR_BIT    = 0;
	localparam int CTRL_INVAL_BIT = 16;
	localparam int CTRL_SETST_BIT = 17;
	localparam int CTRL_CLRST_BIT = 18;
	localparam int VID_W          = 12;
	localparam int PORTS          = 17;

	localparam logic DIR_READ = 1'b1;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  CMD_RST        = 8'h00;
	localparam logic [15:0] INDEX_RST      = 16'h0000;
	localparam logic [31:0] AGE_PERIOD_RST = 32'h0000_0400;

	typedef struct packed {
		logic             mcast;   // top station address bit
		logic [PORTS-1:0] map;     // port number in [4:0] or group map
		logic [2:0]       prio;
	} swta_learn_t;

	typedef struct packed {
		logic             valid;
		logic             static_flag;
		logic             age;
		logic             mcast;
		logic [PORTS-1:0] map;
		logic [2:0]       prio;
	} swta_addr_entry_t;

	typedef struct packed {
		logic [PORTS-1:0] untag_map;
		logic [PORTS-1:0] vlan_forward_port_map;
		logic [4:0]       spanning_tree_index;
		logic             valid;
	} swta_vlan_entry_t;

	typedef enum logic [1:0] {
		VT_IDLE,
		VT_ACCESS,
		VT_FINISH
	} swta_vt_state_t;

endpackage

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
	localparam logic [16:0] GRP_MAP = 17'h1ABCD;
	logic        clk;
	logic        rst_b;
	logic        cyc, stb, we;
	logic [9:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic        ack;
	logic        lrn_req, acc_req;
	logic [3:0]  lrn_idx, acc_idx;
	swta_pkg::swta_learn_t lrn_dat;
	int          num_errors;
	int          cmp_count;

	swta_switch_table_regs #(.ENTRIES(16), .VLAN_DEPTH(4096)) dut_u (
		.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.learn_req_i(lrn_req), .learn_idx_i(lrn_idx), .learn_data_i(lrn_dat),
		.access_req_i(acc_req), .access_idx_i(acc_idx));

	always #2 clk = ~clk;

	// ---------------------------------------------------------------
	// bus and table tasks
	// ---------------------------------------------------------------
	task automatic final_report();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// classic cycle; ack and data are taken at the same edge
	// no cycle limit here: only the watchdog ends a wait for ack
	task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'b00};
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, idx, d, q);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, idx, 32'h0, q);
		check($sformatf("reg %h", idx), q & mask, exp);
	endtask

	task automatic learn(input logic [3:0] i, input logic [20:0] d);
		@(posedge clk);
		lrn_req <= 1'b1;
		lrn_idx <= i;
		lrn_dat <= d;
		@(posedge clk);
		lrn_req <= 1'b0;
	endtask

	task automatic entry(input logic [3:0] i, input logic [31:0] mask, input logic [31:0] exp);
		wr(8'h4C, {28'h0, i});
		rd(8'h48, mask, exp);
	endtask

	// launch a command and poll until the start bit drops
	task automatic vcmd(input logic [7:0] c);
		logic [31:0] q;
		int n;
		n = 0;
		wr(8'h60, {24'h0, c});
		do begin
			wb(1'b0, 8'h60, 32'h0, q);
			n++;
		end while (q[7] !== 1'b0 && n < 50);
		check("start bit", q & 32'hFF, {31'h0, c[0]});
	endtask

	// ---------------------------------------------------------------
	// watchdog: whole sequence needs well under 3000 cycles
	// ---------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		final_report();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0; rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 10'h000;
		wdat = 32'h0; lrn_req = 1'b0; acc_req = 1'b0; lrn_idx = 4'h0; acc_idx = 4'h0;
		lrn_dat = 21'h0; num_errors = 0; cmp_count = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rd(8'h48, 32'hFFFFFFFF, 32'h0);
		rd(8'h60, 32'hFFFFFFFF, 32'h0);
		rd(8'h61, 32'hFFFFFFFF, 32'h0);
		rd(8'h4D, 32'hFFFFFFFF, 32'h0000_0400);
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		wr(8'h10, 32'hFFFFFFFF);
		rd(8'h10, 32'hFFFFFFFF, 32'h0);
		wr(8'h61, 32'h0000FFFF);
		rd(8'h61, 32'hFFFFFFFF, 32'h0000_0FFF);
		// aging off while fields are checked, so no tick can race the reads
		wr(8'h4D, 32'h0);
		learn(4'h3, {1'b0, 17'h0001A, 3'h5});
		entry(4'h3, 32'hFFFFFFFF, {21'h0, 5'h1A, 1'b0, 2'b11, 3'h5});
		learn(4'h4, {1'b1, GRP_MAP, 3'h2});
		entry(4'h4, 32'hFFFFFFFF, {10'h0, GRP_MAP[16:6], GRP_MAP[5:1], GRP_MAP[0],
			2'b11, 3'h2});
		learn(4'h3, {1'b0, 17'h00005, 3'h7});
		entry(4'h3, 32'hFFFFFFFF, {21'h0, 5'h1A, 1'b0, 2'b11, 3'h5});
		wr(8'h4C, 32'h0001_0003);
		entry(4'h3, 32'h8, 32'h0);
		learn(4'h3, {1'b0, 17'h00002, 3'h1});
		entry(4'h3, 32'hFFFFFFFF, {21'h0, 5'h02, 1'b0, 2'b11, 3'h1});
		wr(8'h4C, 32'h0002_0005);
		learn(4'h5, {1'b0, 17'h00009, 3'h7});
		entry(4'h5, 32'h2F, 32'h28);
		// entry 4 is kept alive by hits, entry 3 is left idle
		// view moves from idle entry 3 to static entry 5 halfway through
		wr(8'h4C, 32'h3);
		wr(8'h4D, 32'h8);
		for (int k = 0; k < 12; k++) begin
			if (k == 6) wr(8'h4C, 32'h5);
			@(posedge clk);
			acc_req <= 1'b1;
			acc_idx <= 4'h4;
			@(posedge clk);
			acc_req <= 1'b0;
			repeat (2) @(posedge clk);
		end
		wr(8'h4D, 32'h0);
		entry(4'h3, 32'h8, 32'h0);
		entry(4'h4, 32'h8, 32'h8);
		entry(4'h5, 32'h28, 32'h28);
		// two entries written, first one read back
		wr(8'h61, 32'h5);
		wr(8'h63, 32'h8765_4321);
		wr(8'h64, 32'hAB);
		vcmd(8'h80);
		wr(8'h61, 32'h6);
		wr(8'h63, 32'h1111_2222);
		wr(8'h64, 32'h33);
		vcmd(8'h80);
		wr(8'h61, 32'h5);
		vcmd(8'h81);
		rd(8'h63, 32'hFFFFFFFF, 32'h8765_4321);
		rd(8'h64, 32'hFFFFFFFF, 32'hAB);
		final_report();
	end
endmodule
